// File: hdl/adc_parallel_host_port.sv
// parallel host port: strobe decode, control registers, read path
`timescale 1ns/1ps
`include "host_port_params.svh"
module adc_parallel_host_port (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic select_a_n,
  input wire logic select_b,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [`CTRL_W:0] data_in,
  input wire logic [`DATA_W-1:0] sample_word,
  input wire logic sample_valid,
  output logic [`DATA_W-1:0] data_out,
  output logic data_oe,
  output logic sample_ready_flag,
  output logic [`CTRL_W-1:0] ctrl0_out,
  output logic [`CTRL_W-1:0] ctrl1_out,
  output logic [3:0] channel_diff
);
  import host_port_pkg::*;
  // ---------------------------------------------
  // state and decoded strobes
  // ---------------------------------------------
  state_t s_r;
  state_t s_nxt;
  logic sa;
  logic sb;
  logic rn;
  logic wn;
  logic comb;
  logic sel;
  logic rd_q;
  logic wr_q;
  logic rd_start;
  logic wr_end;

  // ---------------------------------------------
  // decode helpers
  // ---------------------------------------------
  // read qualifier, write strobe must stay inactive
  function automatic logic read_qual(logic cm, logic sv, logic rv, logic wv);
    read_qual = cm ? (sv && wv) : (sv && !rv && wv);
  endfunction

  // write qualifier, read strobe must stay inactive in separate mode only
  function automatic logic write_qual(logic cm, logic sv, logic rv, logic wv);
    write_qual = cm ? (sv && !wv) : (sv && !wv && rv);
  endfunction

  // channel arrangement from the differential bit
  function automatic logic [3:0] chan_map(logic diff);
    chan_map = diff ? `CHAN_PAIRS : `CHAN_SINGLE;
  endfunction

  // ---------------------------------------------
  // pin synchronisers and access sequencing
  // ---------------------------------------------
  always_comb begin
    s_nxt = s_r;
    // two flip-flops on each select and strobe pin before any decode; data_in is used unsynchronised
    s_nxt.sel_a_n_s = {s_r.sel_a_n_s[1:0], select_a_n};
    s_nxt.sel_b_s = {s_r.sel_b_s[1:0], select_b};
    s_nxt.rd_n_s = {s_r.rd_n_s[1:0], rd_n};
    s_nxt.wr_n_s = {s_r.wr_n_s[1:0], wr_n};
    sa = s_r.sel_a_n_s[1];
    sb = s_r.sel_b_s[1];
    rn = s_r.rd_n_s[1];
    wn = s_r.wr_n_s[1];
    comb = s_r.ctrl1[`BIT_COMBINED];
    sel = !sa && sb;
    rd_q = read_qual(comb, sel, rn, wn);
    wr_q = write_qual(comb, sel, rn, wn);
    rd_start = (s_r.acc == IDLE) && rd_q;
    wr_end = (s_r.acc == WRITE) && !wr_q;
    // new sample raises the flag, a read start below clears it
    if (sample_valid) begin
      s_nxt.flag = 1'b1;
    end
    case (s_r.acc)
      IDLE: begin
        if (rd_q) begin
          s_nxt.acc = READ;
          s_nxt.dout = sample_word;
          s_nxt.doe = 1'b1;
          s_nxt.flag = 1'b0;
        end else if (wr_q) begin
          s_nxt.acc = WRITE;
        end
      end
      READ: begin
        // first qualifier to go inactive ends the read
        if (!rd_q) begin
          s_nxt.acc = IDLE;
          s_nxt.doe = 1'b0;
        end
      end
      WRITE: begin
        // word is taken when the strobe ends
        if (!wr_q) begin
          s_nxt.acc = IDLE;
          if (data_in[`CTRL_ADDR_BIT]) begin
            s_nxt.ctrl1 = data_in[`CTRL_W-1:0];
          end else begin
            s_nxt.ctrl0 = data_in[`CTRL_W-1:0];
          end
        end
      end
      default: begin
        s_nxt.acc = IDLE;
        s_nxt.doe = 1'b0;
      end
    endcase
    s_nxt.chan = chan_map(s_r.ctrl0[`BIT_DIFF]);
  end

  // ---------------------------------------------
  // state register
  // ---------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '{sel_a_n_s: `SYNC_HIGH, sel_b_s: `SYNC_LOW, rd_n_s: `SYNC_HIGH,
               wr_n_s: `SYNC_HIGH, acc: IDLE, ctrl0: `CTRL0_RESET, ctrl1: `CTRL1_RESET,
               dout: `WORD_RESET, doe: 1'b0, flag: 1'b0, chan: `CHAN_SINGLE};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------
  // outputs
  // ---------------------------------------------
  assign data_out = s_r.dout;
  assign data_oe = s_r.doe;
  assign sample_ready_flag = s_r.flag;
  assign ctrl0_out = s_r.ctrl0;
  assign ctrl1_out = s_r.ctrl1;
  assign channel_diff = s_r.chan;

  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  oe_only_read_a: assert property (@(posedge clock) disable iff (!rst_b)
    data_oe |-> s_r.acc == READ) else $error("bus driven outside read");

  read_start_a: assert property (@(posedge clock) disable iff (!rst_b)
    rd_start |=> (data_oe && data_out == $past(sample_word)))
    else $error("read start wrong");

  flag_drop_a: assert property (@(posedge clock) disable iff (!rst_b)
    rd_start |=> !sample_ready_flag) else $error("ready flag kept on read");

  flag_set_a: assert property (@(posedge clock) disable iff (!rst_b)
    (sample_valid && !rd_start) |=> sample_ready_flag) else $error("ready flag not set");

  read_end_a: assert property (@(posedge clock) disable iff (!rst_b)
    (s_r.acc == READ && !rd_q) |=> !data_oe) else $error("read not ended");

  read_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
    (s_r.acc == READ && rd_q) |=> (data_oe && $stable(data_out)))
    else $error("read word not held");

  write_load_a: assert property (@(posedge clock) disable iff (!rst_b)
    (wr_end && !data_in[`CTRL_ADDR_BIT]) |=> ctrl0_out == $past(data_in[`CTRL_W-1:0]))
    else $error("ctrl0 not loaded");

  write_load1_a: assert property (@(posedge clock) disable iff (!rst_b)
    (wr_end && data_in[`CTRL_ADDR_BIT]) |=> ctrl1_out == $past(data_in[`CTRL_W-1:0]))
    else $error("ctrl1 not loaded");

  ctrl_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
    !wr_end |=> ($stable(ctrl0_out) && $stable(ctrl1_out)))
    else $error("control changed without write");

  sep_read_a: assert property (@(posedge clock) disable iff (!rst_b)
    (!comb && rn && s_r.acc == IDLE) |=> s_r.acc != READ) else $error("read without strobe");

  sep_write_a: assert property (@(posedge clock) disable iff (!rst_b)
    (!comb && sel && !wn && rn && s_r.acc == IDLE) |=> s_r.acc == WRITE)
    else $error("write strobe not taken");

  both_strobe_a: assert property (@(posedge clock) disable iff (!rst_b)
    (!comb && sel && !wn && !rn && s_r.acc == IDLE) |=> s_r.acc == IDLE)
    else $error("both strobes started access");

  comb_dir_a: assert property (@(posedge clock) disable iff (!rst_b)
    (comb && sel && !wn && s_r.acc == IDLE) |=> s_r.acc == WRITE) else $error("dir low not write");

  comb_read_a: assert property (@(posedge clock) disable iff (!rst_b)
    (comb && sel && wn && s_r.acc == IDLE) |=> s_r.acc == READ) else $error("dir high not read");

  qual_a: assert property (@(posedge clock) disable iff (!rst_b)
    (!sel && s_r.acc == IDLE) |=> s_r.acc == IDLE) else $error("access without select");

  chan_pairs_a: assert property (@(posedge clock) disable iff (!rst_b)
    ctrl0_out[`BIT_DIFF] |=> channel_diff == `CHAN_PAIRS) else $error("pairs not selected");

  chan_single_a: assert property (@(posedge clock) disable iff (!rst_b)
    !ctrl0_out[`BIT_DIFF] |=> channel_diff == `CHAN_SINGLE) else $error("singles not selected");

endmodule // adc_parallel_host_port

// File: hdl/host_port_params.svh
// constants of the parallel host port
`ifndef HOST_PORT_PARAMS_SVH
`define HOST_PORT_PARAMS_SVH
`define DATA_W 10
`define CTRL_W 10
`define CLK_PERIOD_NS 10
`define DAV_DROP_NS 12
`define DAV_DROP_CYC ((`DAV_DROP_NS) / (`CLK_PERIOD_NS))
`define BIT_COMBINED 6
`define BIT_DIFF 3
`define CTRL_ADDR_BIT 10
`define CTRL0_RESET 10'h000
`define CTRL1_RESET 10'h030
`define WORD_RESET 10'h000
`define SYNC_HIGH 3'h7
`define SYNC_LOW 3'h0
`define CHAN_SINGLE 4'hF
`define CHAN_PAIRS 4'h3
`endif

// File: hdl/host_port_pkg.sv
// types of the parallel host port
package host_port_pkg;
  typedef enum logic [1:0] {
    IDLE = 2'b00,
    READ = 2'b01,
    WRITE = 2'b10
  } access_t;
  typedef struct packed {
    logic [2:0] sel_a_n_s;
    logic [2:0] sel_b_s;
    logic [2:0] rd_n_s;
    logic [2:0] wr_n_s;
    access_t acc;
    logic [9:0] ctrl0;
    logic [9:0] ctrl1;
    logic [9:0] dout;
    logic doe;
    logic flag;
    logic [3:0] chan;
  } state_t;
endpackage

// File: tb/adc_parallel_host_port_test.sv
// self-checking bench of the parallel host port
`timescale 1ns/1ps
module adc_parallel_host_port_test;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic select_a_n, select_b, rd_n, wr_n, data_oe, sample_ready_flag;
  logic [10:0] data_in;
  logic [9:0] sample_word = 10'h2A5;
  logic sample_valid = 1'b0;
  logic [9:0] data_out, ctrl0_out, ctrl1_out;
  logic [3:0] channel_diff;
  int n_mismatch = 0;
  int total_checks = 0;
  always #5 clock = ~clock;
  host_model u_host (.clock(clock), .select_a_n(select_a_n), .select_b(select_b),
    .rd_n(rd_n), .wr_n(wr_n), .data_in(data_in));
  adc_parallel_host_port u_dut (.clock(clock), .rst_b(rst_b), .select_a_n(select_a_n),
    .select_b(select_b), .rd_n(rd_n), .wr_n(wr_n), .data_in(data_in),
    .sample_word(sample_word), .sample_valid(sample_valid), .data_out(data_out),
    .data_oe(data_oe), .sample_ready_flag(sample_ready_flag), .ctrl0_out(ctrl0_out),
    .ctrl1_out(ctrl1_out), .channel_diff(channel_diff));
  task automatic cmp_bit(input string s, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %b seen %b", s, e, g);
    end
  endtask
  task automatic cmp(input string s, input logic [9:0] e, input logic [9:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic rd_check(input logic comb);
    u_host.xfer(1'b1, comb, 11'h000);
    cmp_bit("oe", 1'b1, data_oe);
    cmp("data", 10'h2A5, data_out);
    cmp_bit("flag", 1'b0, sample_ready_flag);
    repeat (3) @(posedge clock);
    #1 cmp_bit("oe_off", 1'b0, data_oe);
  endtask
  task automatic sep_mode;
    u_host.xfer(1'b0, 1'b0, 11'h008);
    cmp("ctrl0", 10'h008, ctrl0_out);
    cmp("chan", 10'h003, {6'h00, channel_diff});
    sample_valid = 1'b1;
    @(posedge clock) #1 sample_valid = 1'b0;
    @(posedge clock) #1 cmp_bit("flag_set", 1'b1, sample_ready_flag);
    rd_check(1'b0);
  endtask
  task automatic comb_mode;
    u_host.xfer(1'b0, 1'b0, 11'h470);
    cmp("ctrl1", 10'h070, ctrl1_out);
    sample_valid = 1'b1;
    @(posedge clock) #1 sample_valid = 1'b0;
    @(posedge clock) #1 cmp_bit("flag_set_c", 1'b1, sample_ready_flag);
    rd_check(1'b1);
    u_host.xfer(1'b0, 1'b1, 11'h001);
    cmp("ctrl0_c", 10'h001, ctrl0_out);
    cmp("chan_c", 10'h00F, {6'h00, channel_diff});
  endtask
  initial begin
    repeat (12) @(posedge clock);
    #1 rst_b = 1'b1;
    repeat (3) @(posedge clock);
    #1 cmp("ctrl1_rst", 10'h030, ctrl1_out);
    cmp_bit("oe_rst", 1'b0, data_oe);
    sep_mode();
    comb_mode();
    conclude();
  end
endmodule // adc_parallel_host_port_test

// File: tb/host_model.sv
// host bus master model for the parallel port
`timescale 1ns/1ps
module host_model (
  input wire logic clock,
  output logic select_a_n,
  output logic select_b,
  output logic rd_n,
  output logic wr_n,
  output logic [10:0] data_in
);
  // conversion clock seen by the host, used to place combined reads
  logic sample_clock = 1'b0;
  always #80 sample_clock = ~sample_clock;
  initial begin
    select_a_n = 1'b1;
    select_b = 1'b0;
    rd_n = 1'b1;
    wr_n = 1'b1;
    data_in = 11'h000;
  end
  task automatic xfer(input logic rd, input logic comb, input logic [10:0] d);
    @(posedge clock) #1;
    wr_n = rd;
    rd_n = comb | ~rd;
    data_in = d;
    if (comb && rd) begin
      @(negedge sample_clock);
      @(posedge clock);
    end
    @(posedge clock) #1;
    select_b = 1'b1;
    select_a_n = 1'b0;
    repeat (5) @(posedge clock);
    #1;
    select_a_n = 1'b1;
    select_b = 1'b0;
    rd_n = 1'b1;
    repeat (rd ? 1 : 5) @(posedge clock);
    #1;
    data_in = ~d;
  endtask
endmodule // host_model
